// ---- can_mode_pkg.sv ----
// Purpose: shared constants and types for the can operating-mode control
// Assumes: 32-bit axi4-lite register bus, one word per register
// Notes: register fields sit in the low bits, upper bits read as zero
package can_mode_pkg;

  // bus widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;

  // register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_IE = 4'h8;
  localparam logic [3:0] OFF_DIAG = 4'hC;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // recessive bits needed to call the bus idle
  localparam logic [3:0] SYNC_BITS = 4'hB;
  localparam logic [3:0] SYNC_LAST = SYNC_BITS - 4'h1;

  // master_control_reg layout, bit 2 down to bit 0
  typedef struct packed {
    logic auto_wakeup_enable;
    logic sleep_request;
    logic init_request;
  } ctrl_t;
  localparam int CTRL_W = 3;
  localparam ctrl_t CTRL_RST = 3'h2;

  // master_status_reg layout, bit 2 down to bit 0
  typedef struct packed {
    logic wake_pending;
    logic sleep_acknowledge;
    logic init_acknowledge;
  } stat_t;
  localparam int STAT_W = 3;
  localparam int STAT_WAKE_BIT = 2;

  // diagnostic_reg layout, bit 2 down to bit 0
  typedef struct packed {
    logic rx_level;
    logic loopback_select;
    logic silent_select;
  } diag_t;
  localparam int DIAG_W = 3;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_RST = 2'h0;

  // operating modes
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_INIT = 2'b01,
    MODE_SYNC = 2'b10,
    MODE_NORMAL = 2'b11
  } mode_t;

endpackage

// ---- can_mode_ctrl.sv ----
// Purpose: operating-mode control of a can controller (sleep, init, normal, test)
// Assumes: bit_tick marks the sample point of each bus bit, from same-clock logic
// Notes: core_tx/core_rx use 1 = recessive; the bus pin passes a two-flop synchroniser
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - reset into sleep, receive pull-up on
// - request sets acknowledge, pull-up then off
// - normal exactly when no acknowledge set
// - eleven recessive bits before bus traffic
// - init left when hardware clears acknowledge
// - init: no traffic, transmit pin recessive
// - entering init keeps configuration unchanged
// - sleep: hardware updates no status bits; wake pending is still set
// - init request during sleep not acknowledged
// - bus activity clears sleep request automatically
// - wake-up interrupt on activity when enabled
// - sleep left after sync, acknowledge cleared
// - silent: receive, send recessive, never start
// - silent: dominant bits looped back internally
// - loop-back: own frames received and stored
// - loop-back: ignore ack errors, pin disregarded
// - combined: receive pin cut, transmit recessive
// - standard and extended identifiers in hardware
module can_mode_ctrl
  import can_mode_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus pins
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  output logic rx_pullup_en,
  // protocol core side
  input wire logic bit_tick,
  input wire logic core_tx,
  output logic core_rx,
  output logic core_active,
  output logic core_tx_allowed,
  output logic core_ack_ignore,
  // wake-up interrupt
  output logic wakeup_irq
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // mode state and acknowledges
  mode_t st_r;
  logic init_ack_r;
  logic sleep_ack_r;
  logic pullup_r;
  // software registers
  ctrl_t ctrl_r;
  logic [SEL_W-1:0] sel_r;
  logic ie_r;
  logic wake_flag_r;
  logic rx_lvl_r;
  // receive pin synchroniser and edge history
  logic rx_m_r;
  logic rx_s_r;
  logic rx_prev_r;
  // bus-idle counter
  logic [3:0] sync_cnt_r;
  // axi write side holding registers
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic wstrb0_r;
  // axi read data next value
  logic [DATA_W-1:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  // decoded helpers
  logic silent;
  logic loop;
  logic rx_eff;
  logic wake_evt;
  logic sync_done;
  logic do_write;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_ie;
  logic wr_diag;
  logic wr_bad;

  assign silent = sel_r[0];
  assign loop = sel_r[1];
  // loop-back feeds the core output back, real pin disregarded
  assign rx_eff = loop ? core_tx : rx_s_r;
  // bus activity while asleep: a recessive-to-dominant edge on the pin
  assign wake_evt = (st_r == MODE_SLEEP) && rx_prev_r && !rx_s_r;
  assign sync_done = (st_r == MODE_SYNC) && bit_tick && rx_eff && (sync_cnt_r == SYNC_LAST);

  // write decode, one write completes when address and data are both held
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  always_comb begin
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_ie = 1'b0;
    wr_diag = 1'b0;
    wr_bad = 1'b0;
    if (!do_write || !wstrb0_r) begin
      wr_bad = 1'b0; // no write, or no byte holding fields
    end else if (waddr_r == OFF_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (waddr_r == OFF_STAT) begin
      wr_stat = 1'b1;
    end else if (waddr_r == OFF_IE) begin
      wr_ie = 1'b1;
    end else if (waddr_r == OFF_DIAG) begin
      wr_diag = 1'b1;
    end else begin
      wr_bad = 1'b1;
    end
  end

  // two-flop synchroniser on the receive pin, idle recessive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_m_r <= bus_receive_pin;
      rx_s_r <= rx_m_r;
      rx_prev_r <= rx_s_r;
    end
  end

  // control register; software write beats the automatic wake-up clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata_r[CTRL_W-1:0];
    end else if (wake_evt && ctrl_r.auto_wakeup_enable) begin
      ctrl_r.sleep_request <= 1'b0;
    end
  end

  a_auto_wake: assert property (wake_evt && ctrl_r.auto_wakeup_enable && !wr_ctrl |=> !ctrl_r.sleep_request)
    else $error("auto wake-up did not clear sleep request");

  // interrupt enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_r <= 1'b0;
    end else if (wr_ie) begin
      ie_r <= wdata_r[0];
    end
  end

  // test selects only change while in init, so entering init keeps them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= SEL_RST;
    end else if (wr_diag && (st_r == MODE_INIT)) begin
      sel_r <= wdata_r[SEL_W-1:0];
    end
  end

  a_init_keeps_cfg: assert property ($rose(init_ack_r) |-> $stable(sel_r) && $stable(ie_r))
    else $error("configuration changed on init entry");

  // wake-up flag, sticky; a new event beats a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flag_r <= 1'b0;
    end else if (wake_evt) begin
      wake_flag_r <= 1'b1;
    end else if (wr_stat && wdata_r[STAT_WAKE_BIT]) begin
      wake_flag_r <= 1'b0;
    end
  end

  a_wake_flag: assert property (wake_evt |=> wake_flag_r)
    else $error("bus activity in sleep left no wake-up flag");

  // receive level status, frozen while asleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_lvl_r <= 1'b1;
    end else if (st_r != MODE_SLEEP) begin
      rx_lvl_r <= rx_eff;
    end
  end

  // bus-idle counter: consecutive recessive bits seen during sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_cnt_r <= '0;
    end else if (st_r != MODE_SYNC) begin
      sync_cnt_r <= '0;
    end else if (bit_tick) begin
      sync_cnt_r <= rx_eff ? sync_cnt_r + 4'h1 : 4'h0;
    end
  end

  a_sleep_frozen: assert property (st_r == MODE_SLEEP && $past(st_r) == MODE_SLEEP |-> $stable(sync_cnt_r) && $stable(rx_lvl_r))
    else $error("hardware status moved during sleep");

  // mode machine with acknowledge bits and pull-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= MODE_SLEEP;
      init_ack_r <= 1'b0;
      sleep_ack_r <= 1'b1;
      pullup_r <= 1'b1;
    end else begin
      case (st_r)
        MODE_SLEEP: begin
          // init request is ignored until sleep request is cleared
          if (!ctrl_r.sleep_request) begin
            if (ctrl_r.init_request) begin
              st_r <= MODE_INIT;
              init_ack_r <= 1'b1;
              sleep_ack_r <= 1'b0;
              pullup_r <= 1'b0;
            end else begin
              st_r <= MODE_SYNC;
            end
          end
        end
        MODE_INIT: begin
          if (!ctrl_r.init_request) begin
            if (ctrl_r.sleep_request) begin
              st_r <= MODE_SLEEP;
              init_ack_r <= 1'b0;
              sleep_ack_r <= 1'b1;
              pullup_r <= 1'b0;
            end else begin
              st_r <= MODE_SYNC;
            end
          end
        end
        MODE_SYNC: begin
          if (ctrl_r.init_request) begin
            st_r <= MODE_INIT;
            init_ack_r <= 1'b1;
            sleep_ack_r <= 1'b0;
            pullup_r <= 1'b0;
          end else if (ctrl_r.sleep_request) begin
            st_r <= MODE_SLEEP;
            init_ack_r <= 1'b0;
            sleep_ack_r <= 1'b1;
            pullup_r <= 1'b0;
          end else if (sync_done) begin
            // acknowledges drop only once the bus is idle
            st_r <= MODE_NORMAL;
            init_ack_r <= 1'b0;
            sleep_ack_r <= 1'b0;
          end
        end
        default: begin
          if (ctrl_r.init_request) begin
            st_r <= MODE_INIT;
            init_ack_r <= 1'b1;
            pullup_r <= 1'b0;
          end else if (ctrl_r.sleep_request) begin
            st_r <= MODE_SLEEP;
            sleep_ack_r <= 1'b1;
            pullup_r <= 1'b0;
          end
        end
      endcase
    end
  end

  sequence s_sync_done;
    sync_done && !ctrl_r.init_request && !ctrl_r.sleep_request;
  endsequence
  sequence s_normal;
    st_r == MODE_NORMAL && !init_ack_r && !sleep_ack_r;
  endsequence

  a_reset_sleep: assert property (!$past(aresetn) |-> st_r == MODE_SLEEP && sleep_ack_r && rx_pullup_en)
    else $error("reset did not leave sleep with pull-up");
  a_ack_pullup: assert property ($rose(init_ack_r) || $rose(sleep_ack_r) |-> !pullup_r ##1 !rx_pullup_en)
    else $error("pull-up still on after acknowledge");
  a_normal_iff: assert property ((st_r == MODE_NORMAL) == (!init_ack_r && !sleep_ack_r))
    else $error("normal mode and acknowledges disagree");
  a_sync_enter: assert property (s_sync_done |=> s_normal)
    else $error("bus idle did not lead to normal mode");
  a_normal_cause: assert property (st_r == MODE_NORMAL && $past(st_r) != MODE_NORMAL |-> $past(sync_cnt_r) == SYNC_LAST)
    else $error("normal mode entered without eleven recessive bits");
  a_sleep_no_init: assert property (st_r == MODE_SLEEP && ctrl_r.sleep_request |=> !init_ack_r)
    else $error("init acknowledged while asleep");

  // pin, core and interrupt outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_transmit_pin <= 1'b1;
      core_rx <= 1'b1;
      core_active <= 1'b0;
      core_tx_allowed <= 1'b0;
      core_ack_ignore <= 1'b0;
      rx_pullup_en <= 1'b1;
      wakeup_irq <= 1'b0;
    end else begin
      // recessive outside normal mode and whenever silent
      bus_transmit_pin <= (st_r != MODE_NORMAL) || silent || core_tx;
      // silent alone lets own dominant bits reach the core; same path serves both id formats
      core_rx <= silent && !loop ? (rx_s_r && core_tx) : rx_eff;
      core_active <= (st_r == MODE_NORMAL);
      core_tx_allowed <= (st_r == MODE_NORMAL) && !silent;
      core_ack_ignore <= loop;
      rx_pullup_en <= pullup_r;
      wakeup_irq <= wake_flag_r && ie_r;
    end
  end

  a_init_recessive: assert property (st_r != MODE_NORMAL |=> bus_transmit_pin && !core_active)
    else $error("transmit pin not recessive outside normal");
  a_silent_tx: assert property (silent |=> bus_transmit_pin && !core_tx_allowed)
    else $error("silent mode drove the bus or allowed transmit");
  a_silent_loop: assert property (silent && !loop && !core_tx |=> !core_rx)
    else $error("silent dominant bit not looped back");
  a_loop_rx: assert property (loop |=> core_rx == $past(core_tx) && core_ack_ignore)
    else $error("loop-back did not feed transmit to receive");

  // axi write channel: hold address and data, answer when both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read decode
  always_comb begin
    rdata_nxt = '0;
    rresp_nxt = RESP_OKAY;
    if (s_axi_araddr == OFF_CTRL) begin
      rdata_nxt[CTRL_W-1:0] = ctrl_r;
    end else if (s_axi_araddr == OFF_STAT) begin
      rdata_nxt[STAT_W-1:0] = {wake_flag_r, sleep_ack_r, init_ack_r};
    end else if (s_axi_araddr == OFF_IE) begin
      rdata_nxt[0] = ie_r;
    end else if (s_axi_araddr == OFF_DIAG) begin
      rdata_nxt[DIAG_W-1:0] = {rx_lvl_r, sel_r};
    end else begin
      rresp_nxt = RESP_SLVERR;
    end
  end

  // axi read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ---- can_bus_node.sv ----
// Purpose: far side of the can mode control: wired-and bus with one other node
// Assumes: one bit time is BIT_DIV controller clocks
// Notes: node_dominant lets the bench play another node pulling the bus low
`timescale 1ns/1ps
module can_bus_node #(
  parameter int BIT_DIV = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus pins of the controller
  input wire logic bus_transmit_pin,
  output logic bus_receive_pin,
  // sample point marker toward the core side
  output logic bit_tick,
  // other node driving dominant
  input wire logic node_dominant
);
  int cnt_r; // clocks within the current bit

  // bit timing: one tick at the sample point of each bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 0;
      bit_tick <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == BIT_DIV - 1) ? 0 : cnt_r + 1;
      bit_tick <= (cnt_r == BIT_DIV - 1);
    end
  end

  // wired-and: recessive only while nobody drives dominant
  assign bus_receive_pin = bus_transmit_pin & ~node_dominant;
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the can mode control
// Assumes: axi4-lite master tasks, bus node model on the pins
// Notes: random sync lengths and core bits from a fixed seed
`timescale 1ns/1ps
module testbench
  import can_mode_pkg::*;
;
  logic aclk = 1'b0; // controller clock
  logic aresetn = 1'b0; // sync reset
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0; // addresses
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [DATA_W-1:0] wdata = '0, rdata; // data words
  logic [3:0] wstrb = 4'hF; // full word writes
  logic [1:0] bresp, rresp; // responses
  logic rx, tx, pu, tick, core_rx, act, tx_ok, ack_ign, irq; // pins
  logic core_tx = 1'b1; // core transmit bit
  logic dom = 1'b0; // other node dominant
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0; // timeout counter

  always #4 aclk = ~aclk;

  can_mode_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_receive_pin(rx),
    .bus_transmit_pin(tx), .rx_pullup_en(pu), .bit_tick(tick), .core_tx(core_tx), .core_rx(core_rx),
    .core_active(act), .core_tx_allowed(tx_ok), .core_ack_ignore(ack_ign), .wakeup_irq(irq));

  can_bus_node #(.BIT_DIV(8)) i_node (.aclk(aclk), .aresetn(aresetn), .bus_transmit_pin(tx),
    .bus_receive_pin(rx), .bit_tick(tick), .node_dominant(dom));

  // expected transmit pin: silent keeps it recessive
  function automatic logic tx_exp(input logic [1:0] s, input logic b);
    return s[0] ? 1'b1 : b;
  endfunction

  // expected core receive bit: loop-back ignores the pin
  function automatic logic rx_exp(input logic [1:0] s, input logic b, input logic d);
    return s[1] ? b : (b & ~d);
  endfunction

  // one comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // axi write, readies sampled before each edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  // axi read with data and response compare
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    hr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // n bit times at one bus level, aligned to the sample point
  task automatic bits(input int n, input logic dm);
    @(posedge aclk iff tick);
    dom <= dm;
    repeat (n) @(posedge aclk iff tick);
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    int k;
    logic b, d;
    logic [1:0] sel, prev;
    void'($urandom(32'ha08e));
    prev = 2'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("pullup", 32'h0000_0001, {31'h0, pu});
    chk("tx_pin", 32'h0000_0001, {31'h0, tx});
    rd(OFF_STAT, 32'h0000_0002, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0003, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0002, RESP_OKAY);
    @(negedge aclk);
    chk("pullup", 32'h0000_0001, {31'h0, pu});
    wr(OFF_IE, 32'h0000_0001, RESP_OKAY);
    wr(4'h2, 32'h0000_0005, RESP_SLVERR);
    rd(4'h2, 32'h0000_0000, RESP_SLVERR);
    for (int m = 0; m < 4; m++) begin
      sel = 2'(m);
      wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
      rd(OFF_STAT, 32'h0000_0001, RESP_OKAY);
      @(negedge aclk);
      chk("pullup", 32'h0000_0000, {31'h0, pu});
      rd(OFF_IE, 32'h0000_0001, RESP_OKAY);
      rd(OFF_DIAG, {29'h0, 1'b1, prev}, RESP_OKAY);
      core_tx <= 1'b0;
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      chk("tx_init", 32'h0000_0001, {31'h0, tx});
      chk("active_init", 32'h0000_0000, {31'h0, act});
      core_tx <= 1'b1;
      wr(OFF_DIAG, {30'h0, sel}, RESP_OKAY);
      rd(OFF_DIAG, {29'h0, 1'b1, sel}, RESP_OKAY);
      wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
      k = 1 + $urandom_range(7); // lead-in plus two edge bits stays below a full idle run
      bits(k, 1'b0);
      bits(1, 1'b1);
      bits(10, 1'b0);
      rd(OFF_STAT, {31'h0, ~sel[1]}, RESP_OKAY);
      bits(1, 1'b0);
      rd(OFF_STAT, 32'h0000_0000, RESP_OKAY);
      repeat (4) begin
        b = 1'($urandom_range(1));
        d = 1'($urandom_range(1));
        @(posedge aclk); // drive on the rising edge
        core_tx <= b;
        dom <= d;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        chk("tx_pin", {31'h0, tx_exp(sel, b)}, {31'h0, tx});
        chk("core_rx", {31'h0, rx_exp(sel, b, d)}, {31'h0, core_rx});
        chk("active", 32'h0000_0001, {31'h0, act});
        chk("tx_allowed", {31'h0, ~sel[0]}, {31'h0, tx_ok});
        chk("ack_ignore", {31'h0, sel[1]}, {31'h0, ack_ign});
      end
      @(posedge aclk);
      dom <= 1'b0;
      core_tx <= 1'b1;
      prev = sel;
    end
    wr(OFF_DIAG, 32'h0000_0000, RESP_OKAY);
    rd(OFF_DIAG, 32'h0000_0007, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(OFF_DIAG, 32'h0000_0000, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    bits(12, 1'b0);
    wr(OFF_CTRL, 32'h0000_0006, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0002, RESP_OKAY);
    @(negedge aclk);
    chk("irq_idle", 32'h0000_0000, {31'h0, irq});
    bits(1, 1'b1);
    bits(12, 1'b0);
    rd(OFF_CTRL, 32'h0000_0004, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0004, RESP_OKAY);
    @(negedge aclk);
    chk("irq_wake", 32'h0000_0001, {31'h0, irq});
    wr(OFF_STAT, 32'h0000_0004, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0000, RESP_OKAY);
    @(negedge aclk);
    chk("irq_clear", 32'h0000_0000, {31'h0, irq});
    // sleep without auto wake-up: software must clear the request
    wr(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
    bits(1, 1'b1);
    rd(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0006, RESP_OKAY);
    @(negedge aclk);
    chk("irq_sleep", 32'h0000_0001, {31'h0, irq});
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    bits(12, 1'b0);
    rd(OFF_STAT, 32'h0000_0004, RESP_OKAY);
    finish_test();
  end
endmodule
